/* abm_access_bank_mapper.sv */
`timescale 1ns/1ps
`include "abm_cfg.svh"
module abm_access_bank_mapper
    import abm_pkg::*;
#(
    parameter logic PIN28 = 1'b0
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire abm_req_t coreReq,
    input wire logic [1:0] sspMaskSel,
    input wire logic pmpMaster,
    output abm_rsp_t coreRsp
);

    ////////////////////////////////////////////////////////////////////////////
    // storage
    logic [7:0] sfrMem_r [192];
    logic [7:0] sspMask_r [2];
    logic [7:0] pmdOut_r [2];
    abm_rsp_t rsp_r;

    function automatic logic [7:0] sfrIdx(input logic [11:0] a);
        logic [11:0] d;
        d = a - `ABM_SFR_LO;
        return d[7:0];
    endfunction : sfrIdx

    function automatic logic implemented(input logic [11:0] a, input logic pin28);
        logic ok;
        ok = 1'b1;
        if (a >= 12'hf60 && a <= 12'hf65) ok = 1'b0;
        if (a[11:4] == 8'hfd && a[3:0] >= 4'hb && a[3:0] <= 4'he) ok = 1'b0;
        if (a[11:4] == 8'hfe && a[2:0] >= 3'h3 && a[2:0] <= 3'h6) ok = 1'b0;
        if (a == `ABM_RSV0_ADDR || a == `ABM_RSV1_ADDR) ok = 1'b0;
        if (pin28 && (a == 12'hf8d || a == 12'hf8c || a == 12'hf84 || a == 12'hf83
                      || (a >= 12'hf6c && a <= 12'hf6f))) ok = 1'b0;
        return ok;
    endfunction : implemented

    logic [7:0] bankSel;
    logic [7:0] ptr0Lo, ptr0Hi, ptr1Lo, ptr1Hi, ptr2Lo, ptr2Hi;
    logic [11:0] ptr2;

    assign bankSel = sfrMem_r[sfrIdx(`ABM_BSR_ADDR)];
    assign ptr0Lo = sfrMem_r[sfrIdx(`ABM_PTR0L_ADDR)];
    assign ptr0Hi = sfrMem_r[sfrIdx(`ABM_PTR0L_ADDR + 12'h001)];
    assign ptr1Lo = sfrMem_r[sfrIdx(`ABM_PTR1L_ADDR)];
    assign ptr1Hi = sfrMem_r[sfrIdx(`ABM_PTR1L_ADDR + 12'h001)];
    assign ptr2Lo = sfrMem_r[sfrIdx(`ABM_PTR2L_ADDR)];
    assign ptr2Hi = sfrMem_r[sfrIdx(`ABM_PTR2H_ADDR)];
    assign ptr2 = {ptr2Hi[3:0], ptr2Lo};

    ////////////////////////////////////////////////////////////////////////////
    // address formation
    logic [11:0] formed;
    logic [7:0] fAddr;
    assign fAddr = coreReq.addr[7:0];

    always_comb begin
        formed = coreReq.addr;
        unique case (coreReq.mode)
            ABM_MOVE: formed = coreReq.addr;
            ABM_INDIRECT: formed = coreReq.addr;
            ABM_DIRECT: begin
                if (coreReq.accessBit) begin
                    formed = {bankSel[3:0], fAddr};
                end else if (fAddr > `ABM_ACC_TOP) begin
                    formed = {`ABM_ACC_HI_BANK, fAddr};
                end else if (coreReq.ilo) begin
                    formed = ptr2 + {4'h0, fAddr};
                end else begin
                    formed = {4'h0, fAddr};
                end
            end
            default: formed = coreReq.addr;
        endcase
    end

    logic hit0, hit1, hit2;
    logic [11:0] tgt0, tgt1, tgt2;
    abm_alias_redirect #(.ALIAS(`ABM_ALIAS0_ADDR)) u_alias0 (
        .addr(formed), .ptrLo(ptr0Lo), .ptrHi(ptr0Hi), .hit(hit0), .target(tgt0));
    abm_alias_redirect #(.ALIAS(`ABM_ALIAS1_ADDR)) u_alias1 (
        .addr(formed), .ptrLo(ptr1Lo), .ptrHi(ptr1Hi), .hit(hit1), .target(tgt1));
    abm_alias_redirect #(.ALIAS(`ABM_ALIAS2_ADDR)) u_alias2 (
        .addr(formed), .ptrLo(ptr2Lo), .ptrHi(ptr2Hi), .hit(hit2), .target(tgt2));

    logic [11:0] physAddr;
    always_comb begin
        physAddr = formed;
        if (hit0) physAddr = tgt0;
        else if (hit1) physAddr = tgt1;
        else if (hit2) physAddr = tgt2;
    end

    logic sfrHit, implHit;
    assign sfrHit = (physAddr >= `ABM_SFR_LO);
    assign implHit = sfrHit && implemented(physAddr, PIN28);

    logic useSspMask, usePmdOut;
    logic sspPort, pmdIdx;
    assign sspPort = (physAddr == `ABM_SSP2_ADDR);
    assign useSspMask = (physAddr == `ABM_SSP1_ADDR && sspMaskSel[0])
                     || (physAddr == `ABM_SSP2_ADDR && sspMaskSel[1]);
    assign usePmdOut = !pmpMaster
                     && (physAddr == `ABM_PMH_ADDR || physAddr == `ABM_PML_ADDR);
    assign pmdIdx = (physAddr == `ABM_PMH_ADDR);

    ////////////////////////////////////////////////////////////////////////////
    // read data
    logic [7:0] rdVal;
    always_comb begin
        rdVal = 8'h00;
        if (!implHit || coreReq.write) rdVal = 8'h00;
        else if (useSspMask) rdVal = sspMask_r[sspPort];
        else if (usePmdOut) rdVal = pmdOut_r[pmdIdx];
        else rdVal = sfrMem_r[sfrIdx(physAddr)];
    end

    ////////////////////////////////////////////////////////////////////////////
    // write path; reserved and absent locations drop the write
    logic doWrite;
    assign doWrite = coreReq.valid && coreReq.write && implHit;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 192; i++) sfrMem_r[i] <= `ABM_RST_VAL;
        end else if (doWrite && !useSspMask && !usePmdOut) begin
            sfrMem_r[sfrIdx(physAddr)] <= coreReq.wdata;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sspMask_r[0] <= `ABM_RST_VAL;
            sspMask_r[1] <= `ABM_RST_VAL;
        end else if (doWrite && useSspMask) begin
            sspMask_r[sspPort] <= coreReq.wdata;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pmdOut_r[0] <= `ABM_RST_VAL;
            pmdOut_r[1] <= `ABM_RST_VAL;
        end else if (doWrite && usePmdOut) begin
            pmdOut_r[pmdIdx] <= coreReq.wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registered answer
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rsp_r <= '0;
        end else begin
            rsp_r.valid <= coreReq.valid;
            rsp_r.sfrHit <= coreReq.valid && sfrHit;
            rsp_r.gprSel <= coreReq.valid && !sfrHit;
            rsp_r.addr <= physAddr;
            rsp_r.rdata <= coreReq.valid ? rdVal : 8'h00;
        end
    end
    assign coreRsp = rsp_r;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    logic plainDirect;
    assign plainDirect = coreReq.valid && coreReq.mode == ABM_DIRECT
                      && !hit0 && !hit1 && !hit2;

    property p_sfr_top;
        @(posedge sys_clk) disable iff (!rst_n)
        coreRsp.valid |-> (coreRsp.sfrHit == (coreRsp.addr >= 12'hf40));
    endproperty
    a_sfr_top: assert property (p_sfr_top) else $error("sfr region decode wrong");

    property p_unimpl_zero;
        @(posedge sys_clk) disable iff (!rst_n)
        coreReq.valid && !coreReq.write && coreReq.mode == ABM_MOVE
            && coreReq.addr >= 12'hf60 && coreReq.addr <= 12'hf65
        |=> coreRsp.rdata == 8'h00 && coreRsp.sfrHit;
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented sfr not zero");

    // the window may sit anywhere, so only the fixed map is held to this
    property p_no_low_sfr_via_access;
        @(posedge sys_clk) disable iff (!rst_n)
        plainDirect && !coreReq.accessBit && (!coreReq.ilo || fAddr > 8'h5f)
        |=> !(coreRsp.addr >= 12'heb0 && coreRsp.addr <= 12'hf5f && coreRsp.sfrHit);
    endproperty
    a_no_low_sfr_via_access: assert property (p_no_low_sfr_via_access)
        else $error("low sfr reached through access bank");

    property p_window;
        @(posedge sys_clk) disable iff (!rst_n)
        plainDirect && !coreReq.accessBit && coreReq.ilo && fAddr <= 8'h5f
        |=> coreRsp.addr == $past(ptr2) + {4'h0, $past(fAddr)}
            && coreRsp.addr - $past(ptr2) <= 12'h05f;
    endproperty
    a_window: assert property (p_window) else $error("window remap wrong");

    property p_no_window;
        @(posedge sys_clk) disable iff (!rst_n)
        plainDirect && !coreReq.accessBit && !coreReq.ilo && fAddr <= 8'h5f
        |=> coreRsp.addr == {4'h0, $past(fAddr)} && coreRsp.gprSel;
    endproperty
    a_no_window: assert property (p_no_window) else $error("window applied outside mode");

    property p_banked;
        @(posedge sys_clk) disable iff (!rst_n)
        plainDirect && coreReq.accessBit
        |=> coreRsp.addr == {$past(bankSel[3:0]), $past(fAddr)};
    endproperty
    a_banked: assert property (p_banked) else $error("banked address wrong");

    property p_high_access;
        @(posedge sys_clk) disable iff (!rst_n)
        plainDirect && !coreReq.accessBit && fAddr > 8'h5f
        |=> coreRsp.addr == {4'hf, $past(fAddr)} && coreRsp.sfrHit;
    endproperty
    a_high_access: assert property (p_high_access) else $error("high access map wrong");

    property p_alias2;
        @(posedge sys_clk) disable iff (!rst_n)
        coreReq.valid && coreReq.mode == ABM_INDIRECT && coreReq.addr == 12'hfdf
        |=> coreRsp.addr == $past(ptr2);
    endproperty
    a_alias2: assert property (p_alias2) else $error("alias not redirected");

    property p_ssp_mask;
        @(posedge sys_clk) disable iff (!rst_n)
        doWrite && useSspMask ##1 coreReq.valid && !coreReq.write
            && coreReq.mode == ABM_MOVE && coreReq.addr == $past(physAddr)
            && useSspMask
        |=> coreRsp.rdata == $past(coreReq.wdata, 2);
    endproperty
    a_ssp_mask: assert property (p_ssp_mask) else $error("shared mask readback wrong");

endmodule : abm_access_bank_mapper

/* abm_cfg.svh */
`ifndef ABM_CFG_SVH
`define ABM_CFG_SVH

// special function register region, top of data memory
`define ABM_SFR_LO 12'hf40
`define ABM_SFR_HI 12'hfff
// low fast-access range and its window span
`define ABM_ACC_TOP 8'h5f
`define ABM_WIN_SPAN 12'h05f
// bank 15, reached by the upper part of the fast-access bank
`define ABM_ACC_HI_BANK 4'hf
// bank selector and pointer locations
`define ABM_BSR_ADDR 12'hfe0
`define ABM_PTR0L_ADDR 12'hfe9
`define ABM_PTR1L_ADDR 12'hfe1
`define ABM_PTR2L_ADDR 12'hfd9
`define ABM_PTR2H_ADDR 12'hfda
// indirect operand alias locations
`define ABM_ALIAS0_ADDR 12'hfef
`define ABM_ALIAS1_ADDR 12'hfe7
`define ABM_ALIAS2_ADDR 12'hfdf
// shared locations
`define ABM_SSP1_ADDR 12'hfc8
`define ABM_SSP2_ADDR 12'hf74
`define ABM_PMH_ADDR 12'hf6f
`define ABM_PML_ADDR 12'hf6e
// reserved locations
`define ABM_RSV0_ADDR 12'hfd4
`define ABM_RSV1_ADDR 12'hf87
// storage reset value
`define ABM_RST_VAL 8'h00

`endif

/* abm_pkg.sv */
package abm_pkg;

    typedef enum logic [1:0] {
        ABM_DIRECT,
        ABM_MOVE,
        ABM_INDIRECT
    } abm_mode_t;

    typedef struct packed {
        logic valid;
        logic write;
        abm_mode_t mode;
        logic accessBit;
        logic ilo;
        logic [11:0] addr;
        logic [7:0] wdata;
    } abm_req_t;

    typedef struct packed {
        logic valid;
        logic sfrHit;
        logic gprSel;
        logic [11:0] addr;
        logic [7:0] rdata;
    } abm_rsp_t;

endpackage : abm_pkg

/* abm_alias_redirect.sv */
`timescale 1ns/1ps
module abm_alias_redirect #(
    parameter logic [11:0] ALIAS = 12'hfef
) (
    input wire logic [11:0] addr,
    input wire logic [7:0] ptrLo,
    input wire logic [7:0] ptrHi,
    output logic hit,
    output logic [11:0] target
);
    // no storage behind the alias: the access lands where the pointer points
    assign hit = (addr == ALIAS);
    assign target = {ptrHi[3:0], ptrLo};
endmodule : abm_alias_redirect

/* abm_core_model.sv */
`timescale 1ns/1ps
`include "abm_cfg.svh"
module abm_core_model
    import abm_pkg::*;
(
    input wire logic sys_clk,
    output abm_req_t coreReq,
    input wire abm_rsp_t coreRsp
);
    initial coreReq = '0;
    ////////////////////////////////////////////////////////////////////////////
    // reserved locations are never written: such a write is not issued
    function automatic abm_req_t mk(input logic wr, input abm_mode_t md, input logic ab,
            input logic il, input logic [11:0] a, input logic [7:0] wd);
        abm_req_t r;
        r = '{valid: 1'b1, write: wr, mode: md, accessBit: ab, ilo: il, addr: a, wdata: wd};
        if (wr && (a == `ABM_RSV0_ADDR || a == `ABM_RSV1_ADDR)) begin
            r.valid = 1'b0;
        end
        return r;
    endfunction : mk

    // idle: fields no longer show the last request
    function automatic abm_req_t idle(input abm_req_t r);
        return {1'b0, ~r[$bits(abm_req_t)-2:0]};
    endfunction : idle

    // one request held over its taking edge, answer read 1 ns after that same edge
    task automatic xfer(input logic wr, input abm_mode_t md, input logic ab, input logic il,
            input logic [11:0] a, input logic [7:0] wd, output abm_rsp_t rs);
        abm_req_t r;
        r = mk(wr, md, ab, il, a, wd);
        @(posedge sys_clk);
        coreReq <= r;
        @(posedge sys_clk);
        coreReq <= idle(r);
        #1;
        rs = coreRsp;
    endtask : xfer

    // write then read of one full address on back-to-back edges
    task automatic wr_then_rd(input logic [11:0] a, input logic [7:0] wd, output abm_rsp_t rs);
        abm_req_t r;
        r = mk(1'b0, ABM_MOVE, 1'b0, 1'b0, a, 8'h00);
        @(posedge sys_clk);
        coreReq <= mk(1'b1, ABM_MOVE, 1'b0, 1'b0, a, wd);
        @(posedge sys_clk);
        coreReq <= r;
        @(posedge sys_clk);
        coreReq <= idle(r);
        #1;
        rs = coreRsp;
    endtask : wr_then_rd
endmodule : abm_core_model

/* access_bank_address_mapper_bench.sv */
`timescale 1ns/1ps
module access_bank_address_mapper_bench
    import abm_pkg::*;
;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [1:0] sspMaskSel = 2'b00;
    logic pmpMaster = 1'b0;
    abm_req_t coreReq;
    abm_rsp_t coreRsp;
    abm_rsp_t rs;
    abm_rsp_t coreRsp28;
    int miscompares = 0;
    int samples_checked = 0;

    always #25 sys_clk = ~sys_clk;

    abm_core_model core (.sys_clk(sys_clk), .coreReq(coreReq), .coreRsp(coreRsp));
    abm_access_bank_mapper #(.PIN28(1'b0)) dut (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .coreReq(coreReq),
        .sspMaskSel(sspMaskSel),
        .pmpMaster(pmpMaster),
        .coreRsp(coreRsp)
    );
    // small-package variant watching the same requests
    abm_access_bank_mapper #(.PIN28(1'b1)) dut28 (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .coreReq(coreReq),
        .sspMaskSel(sspMaskSel),
        .pmpMaster(pmpMaster),
        .coreRsp(coreRsp28)
    );

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] seen);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic rd(input abm_mode_t md, input logic ab, input logic il, input logic [11:0] a);
        core.xfer(1'b0, md, ab, il, a, 8'h00, rs);
    endtask : rd

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        core.xfer(1'b1, ABM_MOVE, 1'b0, 1'b0, a, d, rs);
    endtask : wr

    ////////////////////////////////////////////////////////////////////////////
    task automatic test_storage();
        rd(ABM_MOVE, 1'b0, 1'b0, 12'hfe0);
        chk("bsr reset", 12'h000, 12'(rs.rdata));
        chk("valid", 12'h001, 12'(rs.valid));
        rd(ABM_MOVE, 1'b0, 1'b0, 12'hf40);
        chk("f40 hit", 12'h001, 12'(rs.sfrHit));
        rd(ABM_MOVE, 1'b0, 1'b0, 12'hf3f);
        chk("f3f gpr", 12'h001, 12'(rs.gprSel));
        chk("f3f hit", 12'h000, 12'(rs.sfrHit));
        wr(12'hf45, 8'h7e);
        rd(ABM_MOVE, 1'b0, 1'b0, 12'hf45);
        chk("f45 data", 12'h07e, 12'(rs.rdata));
        wr(12'hffc, 8'h3c);
        rd(ABM_MOVE, 1'b0, 1'b0, 12'hffc);
        chk("ffc data", 12'h03c, 12'(rs.rdata));
        $display("test storage done");
    endtask : test_storage

    task automatic test_window();
        logic [7:0] f [6] = '{8'h10, 8'h5f, 8'h60, 8'hff, 8'h10, 8'h5f};
        logic il [6] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
        logic [11:0] e [6] = '{12'h310, 12'h35f, 12'hf60, 12'hfff, 12'h010, 12'h05f};
        wr(12'hfd9, 8'h00);
        wr(12'hfda, 8'h03);
        for (int i = 0; i < 6; i++) begin
            rd(ABM_DIRECT, 1'b0, il[i], {4'h0, f[i]});
            chk("access addr", e[i], rs.addr);
        end
        $display("test window done");
    endtask : test_window

    task automatic test_bank();
        wr(12'hfe0, 8'h05);
        rd(ABM_DIRECT, 1'b1, 1'b1, 12'h020);
        chk("banked ilo", 12'h520, rs.addr);
        wr(12'hfe0, 8'h0f);
        rd(ABM_DIRECT, 1'b1, 1'b0, 12'h05f);
        chk("banked f5f", 12'hf5f, rs.addr);
        $display("test bank done");
    endtask : test_bank

    task automatic test_alias();
        rd(ABM_INDIRECT, 1'b0, 1'b0, 12'hfdf);
        chk("alias2 ind", 12'h300, rs.addr);
        rd(ABM_DIRECT, 1'b0, 1'b1, 12'h0df);
        chk("alias2 acc", 12'h300, rs.addr);
        wr(12'hfe9, 8'h44);
        wr(12'hfea, 8'h01);
        rd(ABM_MOVE, 1'b0, 1'b0, 12'hfef);
        chk("alias0", 12'h144, rs.addr);
        $display("test alias done");
    endtask : test_alias

    task automatic test_unimpl();
        wr(12'hf60, 8'ha5);
        rd(ABM_MOVE, 1'b0, 1'b0, 12'hf60);
        chk("f60 zero", 12'h000, 12'(rs.rdata));
        rd(ABM_MOVE, 1'b0, 1'b0, 12'hfd4);
        chk("fd4 zero", 12'h000, 12'(rs.rdata));
        wr(12'hfdc, 8'ha5);
        rd(ABM_MOVE, 1'b0, 1'b0, 12'hfdc);
        chk("fdc zero", 12'h000, 12'(rs.rdata));
        $display("test unimplemented done");
    endtask : test_unimpl

    task automatic test_shared();
        logic [11:0] ad [3] = '{12'hfc8, 12'hf74, 12'hf6e};
        for (int i = 0; i < 3; i++) begin
            @(posedge sys_clk);
            sspMaskSel <= 2'b00;
            pmpMaster <= (i == 2);
            wr(ad[i], 8'h11);
            @(posedge sys_clk);
            sspMaskSel <= 2'b11;
            pmpMaster <= (i != 2);
            core.wr_then_rd(ad[i], 8'h22, rs);
            chk("shared alt", 12'h022, 12'(rs.rdata));
            @(posedge sys_clk);
            sspMaskSel <= 2'b00;
            pmpMaster <= (i == 2);
            rd(ABM_MOVE, 1'b0, 1'b0, ad[i]);
            chk("shared main", 12'h011, 12'(rs.rdata));
        end
        $display("test shared done");
    endtask : test_shared

    task automatic test_pin28();
        wr(12'hf8c, 8'h5a);
        rd(ABM_MOVE, 1'b0, 1'b0, 12'hf8c);
        chk("latd full", 12'h05a, 12'(rs.rdata));
        chk("latd small", 12'h000, 12'(coreRsp28.rdata));
        chk("latd small hit", 12'h001, 12'(coreRsp28.sfrHit));
        $display("test pin28 done");
    endtask : test_pin28

    ////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        test_storage();
        test_window();
        test_bank();
        test_alias();
        test_unimpl();
        test_shared();
        test_pin28();
        tally_and_finish();
    end
endmodule : access_bank_address_mapper_bench
